// [hw/ste_event_unit.sv]
// Functional notes
// (RULE1) Mode 0 (reset value) halts motion on a stall.
// (RULE2) Mode 1 keeps the motor moving after a stall.
// (RULE3) The stall flag is set on every stall in either mode.
// (RULE4) Stall flag goes to 1 and holds until written back; reads 0/1.
// (RULE5) Host clears the stall flag by writing zero.
// (RULE6) Trip arm bits 0..3, reset 0; bit0 input trip, bit1 position trip.
// (RULE7) Input trip holds input line number and subroutine address.
// (RULE8) Armed input trip calls its subroutine when the input becomes true.
// (RULE9) Armed position trip calls its subroutine on reaching target.
// (RULE10) Any trip firing clears the trip arm bits; a trip_arm_wr in the same cycle loads trip_arm_wdata instead.
// (RULE11) Program re-arms the trip bits for each repeated trip.
// (RULE12) Upgrade mode entered only with the exact upgrade code.
// (RULE13) Host finishes any started firmware transfer.
// (RULE14) Live read-only velocity in counts per second, comparable.
// (RULE15) User names: 2 chars, alpha then alnum, not a built-in.
// (RULE16) Dump request reports every defined user variable.
// (RULE17) Stall when lag exceeds the stall tolerance in counts.
// (RULE18) Trips fire once on entry into the true condition.
`timescale 1ns/1ps
`include "ste_cfg.svh"

module ste_event_unit
   import ste_pkg::*;
#(
   parameter int VEL_WIN = `STE_VEL_WIN_CYC
)(
   input  wire logic                          mclk,
   input  wire logic                          resetn,
   input  wire logic signed [`STE_POS_W-1:0]  cmd_pos,
   input  wire logic signed [`STE_POS_W-1:0]  act_pos,
   input  wire logic [`STE_TOL_W-1:0]         stall_tolerance,
   input  wire logic                          stall_response_mode,
   input  wire logic                          stall_flag_clr,
   output logic                               blocked_motor_flag,
   output logic                               motion_halt,
   input  wire logic                          trip_arm_wr,
   input  wire logic [`STE_ARM_W-1:0]         trip_arm_wdata,
   output logic [`STE_ARM_W-1:0]              trip_arm_bits,
   input  wire logic                          input_event_cfg_wr,
   input  wire logic [`STE_IN_SEL_W-1:0]      input_event_cfg_line,
   input  wire logic [`STE_ADDR_W-1:0]        input_event_cfg_addr,
   input  wire logic                          pos_event_cfg_wr,
   input  wire logic signed [`STE_POS_W-1:0]  pos_event_cfg_target,
   input  wire logic [`STE_ADDR_W-1:0]        pos_event_cfg_addr,
   input  wire logic [`STE_IN_NUM-1:0]        in_pins,
   output logic                               sub_call,
   output logic [`STE_ADDR_W-1:0]             sub_call_addr,
   input  wire logic                          flash_update_cmd,
   input  wire logic [`STE_UG_CODE_W-1:0]     flash_update_code,
   output logic                               upgrade_mode,
   output logic signed [`STE_POS_W-1:0]       velocity,
   input  wire logic signed [`STE_POS_W-1:0]  vel_cmp_value,
   output logic                               vel_match,
   input  wire logic                          custom_name_define,
   input  wire logic [`STE_NAME_W-1:0]        custom_name,
   input  wire logic [`STE_VAL_W-1:0]         custom_value,
   input  wire logic                          name_is_builtin,
   output logic                               name_ack,
   output logic                               name_rej,
   input  wire logic                          all_user_vars_dump,
   output logic                               dump_valid,
   output logic [`STE_NAME_W-1:0]             dump_name,
   output logic [`STE_VAL_W-1:0]              dump_value,
   output logic                               dump_done,
   output logic                               uv_busy
);
   // ---------------- Stall ----------------
   logic signed [`STE_POS_W-1:0] lag;
   logic [`STE_POS_W-1:0]        lag_mag;
   logic                         stall_det;

   assign lag       = cmd_pos - act_pos;
   assign lag_mag   = lag[`STE_POS_W-1] ? -lag : lag;
   assign stall_det = lag_mag > {16'h0000, stall_tolerance}; // RULE17

   always_ff @(posedge mclk or negedge resetn) begin
      if (!resetn) begin
         blocked_motor_flag <= 1'b0;
      end else if (stall_det) begin
         blocked_motor_flag <= 1'b1; // RULE3 RULE4
      end else if (stall_flag_clr) begin
         blocked_motor_flag <= 1'b0;
      end
   end

   // Halt is released with the flag so the host sees the stall first
   always_ff @(posedge mclk or negedge resetn) begin
      if (!resetn) begin
         motion_halt <= 1'b0;
      end else if (stall_det && stall_response_mode == `STE_MODE_STOP) begin
         motion_halt <= 1'b1; // RULE1
      end else if (stall_flag_clr || stall_response_mode == `STE_MODE_RUN) begin
         motion_halt <= 1'b0; // RULE2
      end
   end

   // ---------------- Trips ----------------
   logic [`STE_IN_NUM-1:0]   pin_s1_r, pin_s2_r;
   logic [`STE_IN_SEL_W-1:0] in_line_r;
   logic [`STE_ADDR_W-1:0]   in_addr_r, pos_addr_r;
   logic signed [`STE_POS_W-1:0] pos_tgt_r;
   logic                     in_prev_r, at_prev_r, in_now, at_now;
   logic                     in_fire, pos_fire;

   always_ff @(posedge mclk or negedge resetn) begin
      if (!resetn) begin
         pin_s1_r <= '0;
         pin_s2_r <= '0;
      end else begin
         pin_s1_r <= in_pins;
         pin_s2_r <= pin_s1_r;
      end
   end

   always_ff @(posedge mclk or negedge resetn) begin
      if (!resetn) begin
         in_line_r  <= '0;
         in_addr_r  <= '0;
         pos_tgt_r  <= '0;
         pos_addr_r <= '0;
      end else begin
         if (input_event_cfg_wr) begin
            in_line_r <= input_event_cfg_line; // RULE7
            in_addr_r <= input_event_cfg_addr;
         end
         if (pos_event_cfg_wr) begin
            pos_tgt_r  <= pos_event_cfg_target; // RULE9
            pos_addr_r <= pos_event_cfg_addr;
         end
      end
   end

   assign in_now   = pin_s2_r[in_line_r];
   assign at_now   = act_pos == pos_tgt_r;
   assign in_fire  = trip_arm_bits[`STE_ARM_IN_BIT] && in_now
                     && !in_prev_r; // RULE8 RULE18
   assign pos_fire = trip_arm_bits[`STE_ARM_POS_BIT] && at_now
                     && !at_prev_r; // RULE9 RULE18

   always_ff @(posedge mclk or negedge resetn) begin
      if (!resetn) begin
         in_prev_r <= 1'b0;
         at_prev_r <= 1'b0;
      end else begin
         in_prev_r <= in_now;
         at_prev_r <= at_now;
      end
   end

   // A re-arm written in the firing cycle survives, so no event is lost
   always_ff @(posedge mclk or negedge resetn) begin
      if (!resetn) begin
         trip_arm_bits <= `STE_ARM_RST; // RULE6
      end else if (trip_arm_wr) begin
         trip_arm_bits <= trip_arm_wdata; // RULE6
      end else if (in_fire || pos_fire) begin
         trip_arm_bits <= `STE_ARM_RST; // RULE10
      end
   end

   // Input trip wins a tie; both arms are dropped unless a trip_arm_wr in that cycle loads trip_arm_wdata
   always_ff @(posedge mclk or negedge resetn) begin
      if (!resetn) begin
         sub_call      <= 1'b0;
         sub_call_addr <= '0;
      end else begin
         sub_call <= in_fire || pos_fire;
         if (in_fire) begin
            sub_call_addr <= in_addr_r;
         end else if (pos_fire) begin
            sub_call_addr <= pos_addr_r;
         end
      end
   end

   // ---------------- Upgrade ----------------
   always_ff @(posedge mclk or negedge resetn) begin
      if (!resetn) begin
         upgrade_mode <= 1'b0;
      end else if (flash_update_cmd && flash_update_code == `STE_UG_CODE) begin
         upgrade_mode <= 1'b1; // RULE12
      end
   end

   // ---------------- Velocity ----------------
   // Scale follows the window, so a short window still reads counts/s
   localparam int VEL_SCALE = `STE_NS_PER_S / (VEL_WIN * `STE_CLK_NS);
   logic [31:0]                  win_cnt_r;
   logic signed [`STE_POS_W-1:0] win_start_r, win_delta;

   assign win_delta = act_pos - win_start_r;

   always_ff @(posedge mclk or negedge resetn) begin
      if (!resetn) begin
         win_cnt_r   <= '0;
         win_start_r <= '0;
         velocity    <= '0;
      end else if (win_cnt_r == 32'(VEL_WIN - 1)) begin
         win_cnt_r   <= '0;
         win_start_r <= act_pos;
         velocity    <= 32'(win_delta * VEL_SCALE); // RULE14
      end else begin
         win_cnt_r <= win_cnt_r + 32'h0000_0001;
      end
   end

   assign vel_match = velocity == vel_cmp_value; // RULE14

   // ---------------- User variables ----------------
   ste_mem_if mif ();
   ste_uvar_mem u_mem (.mclk(mclk), .resetn(resetn), .port(mif.mem));

   ste_uv_state_t          st_r;
   logic                   dump_r, hit_r, free_r;
   logic [`STE_UV_AW-1:0]  idx_r, slot_r;
   logic [`STE_NAME_W-1:0] nm_r;
   logic [`STE_VAL_W-1:0]  val_r;
   logic                   name_legal;
   logic [7:0]             c0, c1;

   assign c0 = custom_name[15:8];
   assign c1 = custom_name[7:0];
   assign name_legal = !name_is_builtin
      && ((c0 >= 8'h41 && c0 <= 8'h5a) || (c0 >= 8'h61 && c0 <= 8'h7a))
      && ((c1 >= 8'h41 && c1 <= 8'h5a) || (c1 >= 8'h61 && c1 <= 8'h7a)
          || (c1 >= 8'h30 && c1 <= 8'h39)); // RULE15

   assign mif.raddr = idx_r;
   assign mif.we    = st_r == UV_WR && (hit_r || free_r);
   assign mif.waddr = slot_r;
   assign mif.wdata = '{used: 1'b1, name: nm_r, value: val_r};
   assign uv_busy   = st_r != UV_IDLE;

   always_ff @(posedge mclk or negedge resetn) begin
      if (!resetn) begin
         st_r   <= UV_IDLE;
         dump_r <= 1'b0;
         hit_r  <= 1'b0;
         free_r <= 1'b0;
         idx_r  <= '0;
         slot_r <= '0;
         nm_r   <= '0;
         val_r  <= '0;
      end else begin
         unique case (st_r)
            UV_IDLE: begin
               idx_r  <= '0;
               hit_r  <= 1'b0;
               free_r <= 1'b0;
               if (all_user_vars_dump) begin
                  dump_r <= 1'b1;
                  st_r   <= UV_RD;
               end else if (custom_name_define && name_legal) begin
                  dump_r <= 1'b0;
                  nm_r   <= custom_name;
                  val_r  <= custom_value;
                  st_r   <= UV_RD;
               end
            end
            UV_RD: st_r <= UV_CMP;
            UV_CMP: begin
               if (!dump_r && mif.rdata.used && mif.rdata.name == nm_r) begin
                  hit_r  <= 1'b1;
                  slot_r <= idx_r;
                  st_r   <= UV_WR;
               end else begin
                  if (!dump_r && !mif.rdata.used && !free_r) begin
                     free_r <= 1'b1;
                     slot_r <= idx_r;
                  end
                  idx_r <= idx_r + 4'h1;
                  st_r  <= (idx_r == `STE_UV_LAST)
                           ? (dump_r ? UV_IDLE : UV_WR) : UV_RD;
               end
            end
            UV_WR: st_r <= UV_IDLE;
         endcase
      end
   end

   // Requests arriving while busy are dropped; uv_busy tells the parser
   always_ff @(posedge mclk or negedge resetn) begin
      if (!resetn) begin
         name_ack   <= 1'b0;
         name_rej   <= 1'b0;
         dump_valid <= 1'b0;
         dump_done  <= 1'b0;
         dump_name  <= '0;
         dump_value <= '0;
      end else begin
         name_ack <= st_r == UV_WR && (hit_r || free_r);
         name_rej <= (st_r == UV_IDLE && !all_user_vars_dump
                      && custom_name_define && !name_legal)
                     || (st_r == UV_WR && !hit_r && !free_r); // RULE15
         dump_valid <= st_r == UV_CMP && dump_r && mif.rdata.used; // RULE16
         dump_done  <= st_r == UV_CMP && dump_r && idx_r == `STE_UV_LAST;
         if (st_r == UV_CMP && dump_r) begin
            dump_name  <= mif.rdata.name;
            dump_value <= mif.rdata.value;
         end
      end
   end

   // ---------------- Checks ----------------
   sequence s_trip_fire;
      in_fire || pos_fire;
   endsequence

   sequence s_call_disarm;
      sub_call && trip_arm_bits == `STE_ARM_RST;
   endsequence

   a_stall_sets_flag: assert property ( // RULE3
      @(posedge mclk) disable iff (!resetn)
      stall_det |=> blocked_motor_flag)
      else $error("stall did not set flag");

   a_flag_holds: assert property ( // RULE4
      @(posedge mclk) disable iff (!resetn)
      blocked_motor_flag && !stall_flag_clr |=> blocked_motor_flag)
      else $error("stall flag dropped without clear");

   a_stop_mode_halts: assert property ( // RULE1
      @(posedge mclk) disable iff (!resetn)
      stall_det && stall_response_mode == `STE_MODE_STOP |=> motion_halt)
      else $error("stall did not halt motion");

   a_run_mode_moves: assert property ( // RULE2
      @(posedge mclk) disable iff (!resetn)
      stall_response_mode == `STE_MODE_RUN
      && $past(stall_response_mode) == `STE_MODE_RUN |-> !motion_halt)
      else $error("motion halted in run mode");

   a_trip_disarms: assert property ( // RULE10
      @(posedge mclk) disable iff (!resetn)
      s_trip_fire and !trip_arm_wr |=> s_call_disarm)
      else $error("trip did not call and disarm");

   a_in_trip_addr: assert property ( // RULE8
      @(posedge mclk) disable iff (!resetn)
      in_fire |=> sub_call && sub_call_addr == $past(in_addr_r))
      else $error("input trip wrong address");

   a_trip_once: assert property ( // RULE18
      @(posedge mclk) disable iff (!resetn)
      sub_call |-> !$past(sub_call) || $past(trip_arm_wr, 2))
      else $error("trip fired twice");

   a_upgrade_code: assert property ( // RULE12
      @(posedge mclk) disable iff (!resetn)
      $rose(upgrade_mode) |->
      $past(flash_update_cmd) && $past(flash_update_code) == `STE_UG_CODE)
      else $error("upgrade without exact code");

   a_name_legal: assert property ( // RULE15
      @(posedge mclk) disable iff (!resetn)
      st_r == UV_IDLE && custom_name_define && !all_user_vars_dump
      && !name_legal |=> name_rej && !uv_busy)
      else $error("illegal name not rejected");

   a_dump_ends: assert property ( // RULE16
      @(posedge mclk) disable iff (!resetn)
      st_r == UV_IDLE && all_user_vars_dump |-> ##[32:33] dump_done)
      else $error("dump did not finish");
endmodule : ste_event_unit

// [hw/ste_cfg.svh]
`ifndef STE_CFG_SVH
`define STE_CFG_SVH

`define STE_POS_W         32
`define STE_ADDR_W        16
`define STE_TOL_W         16
`define STE_MODE_STOP     1'h0
`define STE_MODE_RUN      1'h1
`define STE_ARM_W         2
`define STE_ARM_RST       2'h0
`define STE_ARM_IN_BIT    0
`define STE_ARM_POS_BIT   1
`define STE_IN_NUM        4
`define STE_IN_SEL_W      2
`define STE_UG_CODE_W     24
`define STE_UG_CODE       24'h2d1b46
`define STE_CLK_NS        50
`define STE_VEL_WIN_NS    1000000
`define STE_VEL_WIN_CYC   (`STE_VEL_WIN_NS / `STE_CLK_NS)
`define STE_NS_PER_S      32'h3b9a_ca00
`define STE_UV_DEPTH      16
`define STE_UV_AW         4
`define STE_UV_LAST       4'hf
`define STE_NAME_W        16
`define STE_VAL_W         32
`define STE_UV_W          49

`endif

// [hw/ste_pkg.sv]
`include "ste_cfg.svh"

package ste_pkg;
   typedef enum logic [2:0] {
      UV_IDLE,
      UV_RD,
      UV_CMP,
      UV_WR
   } ste_uv_state_t;

   typedef struct packed {
      logic                     used;
      logic [`STE_NAME_W-1:0]   name;
      logic [`STE_VAL_W-1:0]    value;
   } ste_uv_entry_t;
endpackage : ste_pkg

// [hw/ste_mem_if.sv]
`timescale 1ns/1ps
`include "ste_cfg.svh"

interface ste_mem_if;
   import ste_pkg::*;
   logic                   we;
   logic [`STE_UV_AW-1:0]  waddr;
   ste_uv_entry_t          wdata;
   logic [`STE_UV_AW-1:0]  raddr;
   ste_uv_entry_t          rdata;

   modport ctl (output we, output waddr, output wdata, output raddr,
                input rdata);
   modport mem (input we, input waddr, input wdata, input raddr,
                output rdata);
endinterface : ste_mem_if

// [hw/ste_uvar_mem.sv]
`timescale 1ns/1ps
`include "ste_cfg.svh"

module ste_uvar_mem
   import ste_pkg::*;
(
   input  wire logic  mclk,
   input  wire logic  resetn,
   ste_mem_if.mem     port
);
   ste_uv_entry_t store_r [`STE_UV_DEPTH];

   // Per-entry reset so an empty table reads as unused after power-up
   for (genvar i = 0; i < `STE_UV_DEPTH; i++) begin : g_ent
      always_ff @(posedge mclk or negedge resetn) begin
         if (!resetn) begin
            store_r[i] <= '0;
         end else if (port.we && port.waddr == `STE_UV_AW'(i)) begin
            store_r[i] <= port.wdata;
         end
      end
   end

   always_ff @(posedge mclk or negedge resetn) begin
      if (!resetn) begin
         port.rdata <= '0;
      end else begin
         port.rdata <= store_r[port.raddr];
      end
   end
endmodule : ste_uvar_mem

// [dv/ste_host_model.sv]
`timescale 1ns/1ps
`include "ste_cfg.svh"

module ste_host_model (
   input  wire logic                  mclk,
   output logic                       stall_flag_clr,
   output logic                       trip_arm_wr,
   output logic [`STE_ARM_W-1:0]      trip_arm_wdata
);
   initial begin
      stall_flag_clr = 1'h0;
      trip_arm_wr    = 1'h0;
      trip_arm_wdata = 2'h0;
   end

   // Device never drops the flag by itself, so the host writes zero
   task clear_flag();
      stall_flag_clr = 1'h1;
      @(posedge mclk);
      #1 stall_flag_clr = 1'h0;
      // Idle edge so back-to-back calls give separate pulses
      @(posedge mclk);
      #1;
   endtask : clear_flag

   // Trips are one-shot; the program re-arms before each repeat
   task arm(input logic [`STE_ARM_W-1:0] v);
      trip_arm_wr    = 1'h1;
      trip_arm_wdata = v;
      @(posedge mclk);
      #1 trip_arm_wr = 1'h0;
      @(posedge mclk);
      #1;
   endtask : arm
endmodule : ste_host_model

// [dv/stall_and_trip_event_unit_test.sv]
`timescale 1ns/1ps
`include "ste_cfg.svh"

module stall_and_trip_event_unit_test;
   import ste_pkg::*;
   logic               mclk, resetn, stall_response_mode, stall_flag_clr;
   logic               blocked_motor_flag, motion_halt, trip_arm_wr;
   logic               input_event_cfg_wr, pos_event_cfg_wr, sub_call;
   logic               flash_update_cmd, upgrade_mode, vel_match, d;
   logic               custom_name_define, name_is_builtin, name_ack;
   logic               name_rej, all_user_vars_dump, dump_valid;
   logic               dump_done, uv_busy;
   logic signed [31:0] cmd_pos, act_pos, pos_event_cfg_target;
   logic signed [31:0] velocity, vel_cmp_value;
   logic [31:0]        custom_value, dump_value, rs;
   logic [15:0]        stall_tolerance, input_event_cfg_addr, dump_name;
   logic [15:0]        pos_event_cfg_addr, sub_call_addr, custom_name;
   logic [15:0]        en[$];
   logic [31:0]        ev[$];
   logic [1:0]         trip_arm_wdata, trip_arm_bits, input_event_cfg_line;
   logic [3:0]         in_pins;
   logic [23:0]        flash_update_code;
   int                 fails, samples_checked, n, i, k;
   logic [15:0]        nmtab[5] = '{16'h5032, 16'h4b31, 16'h3250,
                                    16'h502a, 16'h5052};

   ste_event_unit #(.VEL_WIN(20)) dut_u (.mclk, .resetn, .cmd_pos,
      .act_pos, .stall_tolerance, .stall_response_mode, .stall_flag_clr,
      .blocked_motor_flag, .motion_halt, .trip_arm_wr, .trip_arm_wdata,
      .trip_arm_bits, .input_event_cfg_wr, .input_event_cfg_line,
      .input_event_cfg_addr, .pos_event_cfg_wr, .pos_event_cfg_target,
      .pos_event_cfg_addr, .in_pins, .sub_call, .sub_call_addr,
      .flash_update_cmd, .flash_update_code, .upgrade_mode, .velocity,
      .vel_cmp_value, .vel_match, .custom_name_define, .custom_name,
      .custom_value, .name_is_builtin, .name_ack, .name_rej,
      .all_user_vars_dump, .dump_valid, .dump_name, .dump_value,
      .dump_done, .uv_busy);

   ste_host_model host_u (.mclk, .stall_flag_clr, .trip_arm_wr,
      .trip_arm_wdata);

   initial begin
      mclk = 1'h0;
      forever #25 mclk = ~mclk;
   end

   function automatic logic [31:0] rnd();
      rs = rs ^ (rs << 13);
      rs = rs ^ (rs >> 17);
      rs = rs ^ (rs << 5);
      return rs;
   endfunction : rnd

   function automatic logic stall_exp(input int lag, input int tol);
      return (lag < 0 ? -lag : lag) > tol;
   endfunction : stall_exp

   function automatic logic alpha(input logic [7:0] c);
      return (c >= 8'h41 && c <= 8'h5a) || (c >= 8'h61 && c <= 8'h7a);
   endfunction : alpha

   task tick();
      @(posedge mclk);
      #1;
   endtask : tick

   task chk(input string nm, input logic [31:0] e, input logic [31:0] g);
      samples_checked++;
      if (g !== e) begin
         fails++;
         $display("unexpected %s expected %h seen %h", nm, e, g);
      end
   endtask : chk

   task stop_test();
      if (fails == 0 && samples_checked > 0)
         $display("DONE - PASS");
      else
         $display("DONE - FAIL");
      $finish;
   endtask : stop_test

   // Counts sub_call pulses over a fixed span
   task calls(input int c);
      n = 0;
      repeat (c) begin
         tick();
         if (sub_call === 1'h1) n++;
      end
   endtask : calls

   task define(input logic [15:0] nm, input logic [31:0] v,
               input logic bi);
      logic ok;
      int   j;
      ok = alpha(nm[15:8]) && !bi &&
           (alpha(nm[7:0]) || (nm[7:0] >= 8'h30 && nm[7:0] <= 8'h39));
      custom_name = nm;
      custom_value = v;
      name_is_builtin = bi;
      custom_name_define = 1'h1;
      tick();
      custom_name_define = 1'h0;
      chk("uv_busy", ok, uv_busy);
      j = 0;
      while (j < 40 && name_ack !== 1'h1 && name_rej !== 1'h1) begin
         tick();
         j++;
      end
      chk("name_ack", ok, name_ack);
      chk("name_rej", !ok, name_rej);
      if (ok) begin
         k = -1;
         foreach (en[m]) if (en[m] == nm) k = m;
         if (k < 0) begin
            en.push_back(nm);
            ev.push_back(v);
         end else ev[k] = v;
      end
      tick();
   endtask : define

   initial begin
      repeat (20000) @(posedge mclk);
      fails++;
      stop_test();
   end

   initial begin
      rs = 32'h00001de3;
      {resetn, stall_response_mode, input_event_cfg_wr} = 3'h0;
      {pos_event_cfg_wr, flash_update_cmd, custom_name_define} = 3'h0;
      {name_is_builtin, all_user_vars_dump} = 2'h0;
      {cmd_pos, act_pos, pos_event_cfg_target, vel_cmp_value} = '0;
      {custom_value, stall_tolerance, input_event_cfg_addr} = '0;
      {pos_event_cfg_addr, custom_name, input_event_cfg_line} = '0;
      {in_pins, flash_update_code} = '0;
      repeat (4) @(posedge mclk);
      #1 resetn = 1'h1;
      tick();
      chk("arm_rst", 0, trip_arm_bits);
      chk("flag_rst", 0, blocked_motor_flag);
      stall_tolerance = 16'h0014;
      cmd_pos = 32'sh14;
      tick();
      chk("flag_edge", 0, blocked_motor_flag);
      cmd_pos = -32'sh15;
      tick();
      chk("flag", 1, blocked_motor_flag);
      chk("halt", 1, motion_halt);
      host_u.clear_flag();
      chk("clr_busy", 1, blocked_motor_flag);
      cmd_pos = act_pos;
      host_u.clear_flag();
      chk("flag_clr", 0, blocked_motor_flag);
      repeat (12) begin
         rs = rnd();
         stall_response_mode = rs[0];
         stall_tolerance = {8'h0, rs[15:8]};
         n = int'(stall_tolerance) + int'(rs[17:16]) - 1;
         cmd_pos = rs[1] ? act_pos - n : act_pos + n;
         tick();
         d = stall_exp(n, int'(stall_tolerance));
         chk("flag_rnd", d, blocked_motor_flag);
         chk("halt_rnd", d & !rs[0], motion_halt);
         cmd_pos = act_pos;
         host_u.clear_flag();
      end
      for (i = 0; i < 4; i++) begin
         host_u.arm(i[1:0]);
         chk("arm_wr", i, trip_arm_bits);
      end
      for (i = 0; i < 4; i++) begin
         in_pins = 4'h0;
         input_event_cfg_line = i[1:0];
         input_event_cfg_addr = 16'(rnd());
         input_event_cfg_wr = 1'h1;
         tick();
         input_event_cfg_wr = 1'h0;
         host_u.arm(2'h1);
         in_pins[i] = 1'h1;
         calls(6);
         chk("in_call", 1, n);
         chk("in_addr", input_event_cfg_addr, sub_call_addr);
         chk("in_disarm", 0, trip_arm_bits);
         host_u.arm(2'h1);
         calls(6);
         chk("in_refire", 0, n);
      end
      in_pins = 4'h0;
      rs = rnd();
      pos_event_cfg_target = {16'h0, rs[15:0]} + 32'sh64;
      pos_event_cfg_addr = 16'(rnd());
      pos_event_cfg_wr = 1'h1;
      tick();
      pos_event_cfg_wr = 1'h0;
      host_u.arm(2'h2);
      in_pins = 4'hf;
      calls(6);
      chk("in_masked", 0, n);
      for (i = 0; i < 2; i++) begin
         act_pos = pos_event_cfg_target - 1;
         cmd_pos = act_pos;
         host_u.arm(i ? 2'h3 : 2'h2);
         act_pos = pos_event_cfg_target;
         cmd_pos = act_pos;
         calls(4);
         chk("pos_call", 1, n);
         chk("pos_addr", pos_event_cfg_addr, sub_call_addr);
         chk("pos_disarm", 0, trip_arm_bits);
      end
      vel_cmp_value = 32'(3 * (1000000000 / `STE_CLK_NS));
      repeat (70) begin
         act_pos = act_pos + 3;
         cmd_pos = act_pos;
         tick();
      end
      chk("velocity", 32'(3 * (1000000000 / `STE_CLK_NS)), velocity);
      chk("vel_match", 1, vel_match);
      for (i = 0; i < 5; i++) define(nmtab[i], rnd(), i == 4);
      define(16'h5032, rnd(), 1'h0);
      all_user_vars_dump = 1'h1;
      tick();
      all_user_vars_dump = 1'h0;
      k = 0;
      d = 1'h0;
      repeat (40) begin
         if (dump_valid === 1'h1) begin
            chk("dump_name", en[k], dump_name);
            chk("dump_val", ev[k], dump_value);
            k++;
         end
         d = d | (dump_done === 1'h1);
         tick();
      end
      chk("dump_cnt", en.size(), k);
      chk("dump_done", 1, d);
      flash_update_code = 24'h2d1b47;
      flash_update_cmd = 1'h1;
      tick();
      flash_update_cmd = 1'h0;
      tick();
      chk("upg_bad", 0, upgrade_mode);
      flash_update_code = 24'h2d1b46;
      flash_update_cmd = 1'h1;
      tick();
      flash_update_cmd = 1'h0;
      chk("upg", 1, upgrade_mode);
      flash_update_code = 24'h2d1b47;
      flash_update_cmd = 1'h1;
      tick();
      flash_update_cmd = 1'h0;
      tick();
      chk("upg_hold", 1, upgrade_mode);
      stop_test();
   end
endmodule : stall_and_trip_event_unit_test
